// ---- logic/gcs_pkg.sv ----
// Package: offsets, field positions, reset values and states for the global config/status block
package gcs_pkg;
    localparam logic [6:0] GCS_ADDR_GCONF = 7'h00;
    localparam logic [6:0] GCS_ADDR_STATUS = 7'h01;
    localparam logic [6:0] GCS_ADDR_WRCNT = 7'h02;
    localparam logic [6:0] GCS_ADDR_TARGET = 7'h2d;
    localparam logic [6:0] GCS_ADDR_HOLD = 7'h10;
    localparam int GCS_BIT_DIAG0_PP = 12;
    localparam int GCS_BIT_DIAG1_PP = 13;
    localparam int GCS_BIT_SMALL_HYST = 14;
    localparam int GCS_BIT_STOP_EN = 15;
    localparam int GCS_BIT_DIRECT = 16;
    localparam int GCS_BIT_TEST = 17;
    localparam int GCS_BIT_RESET = 0;
    localparam int GCS_BIT_DRV_ERR = 1;
    localparam int GCS_BIT_PUMP_UV = 2;
    localparam int GCS_COIL_A_LSB = 0;
    localparam int GCS_COIL_B_LSB = 16;
    localparam int GCS_COIL_W = 9;
    localparam int GCS_HYST_SH_WIDE = 4;
    localparam int GCS_HYST_SH_NARROW = 5;
    localparam logic [5:0] GCS_CFG_RESET = 6'h00;
    localparam logic [2:0] GCS_STAT_RESET = 3'h1;
    localparam logic [7:0] GCS_CNT_RESET = 8'h00;
    localparam logic [31:0] GCS_TARGET_RESET = 32'h0000_0000;
    localparam logic [4:0] GCS_HOLD_RESET = 5'h00;
    typedef enum logic [1:0] {
        GCS_RUN = 2'b01,
        GCS_HALT = 2'b10
    } gcs_seq_t;
endpackage

// ---- logic/gcs_coil_scale.sv ----
// Scales one signed coil current by the standstill current setting
`timescale 1ns/1ps
module gcs_coil_scale
    import gcs_pkg::*;
#(
    parameter int CW = 9
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [CW-1:0] coil_in,
    input wire logic [4:0] scale,
    output logic [CW-1:0] coil_out
);
    logic [CW-1:0] coil_ff;
    logic [CW-1:0] nxt_coil;
    logic signed [CW+5:0] prod;

    always_comb begin
        // (scale+1)/32 of programmed value, sign kept
        // Seven bits so that a full-scale setting of 32 stays positive
        prod = $signed(coil_in) * $signed({2'b00, scale} + 7'h01);
        nxt_coil = prod[CW+4:5];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            coil_ff <= '0;
        end else begin
            coil_ff <= nxt_coil;
        end
    end

    assign coil_out = coil_ff;
endmodule

// ---- logic/gcs_regs.sv ----
// Global configuration and status registers with UART write counter
`timescale 1ns/1ps
module gcs_regs
    import gcs_pkg::*;
#(
    parameter int FW = 32
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [FW-1:0] reg_wdata,
    input wire logic uart_sel,
    input wire logic uart_wr_done,
    output logic [FW-1:0] reg_rdata,
    input wire logic overtemp,
    input wire logic short_det,
    input wire logic pump_undervoltage,
    input wire logic diag0_event,
    input wire logic diag1_event,
    input wire logic halt_input_pin,
    input wire logic step_req,
    input wire logic [15:0] step_rate,
    input wire logic [15:0] step_rate_ref,
    input wire logic analog_test,
    input wire logic index_normal,
    output logic first_diagnostic_pin_o,
    output logic first_diagnostic_pin_oe,
    output logic second_diagnostic_pin_o,
    output logic second_diagnostic_pin_oe,
    output logic step_out,
    output logic motor_standstill,
    output logic rate_above,
    output logic driver_enable,
    output logic direct_active,
    output logic auto_regulation_en,
    output logic [GCS_COIL_W-1:0] coil_a_current,
    output logic [GCS_COIL_W-1:0] coil_b_current,
    output logic encoder_index_pin,
    output logic encoder_index_test
);
    logic [5:0] cfg_ff, nxt_cfg;
    logic [2:0] global_status_flags_ff, nxt_stat;
    logic [7:0] uart_write_counter_ff, nxt_cnt;
    logic [31:0] target_position_register_ff, nxt_target;
    logic [4:0] standstill_current_setting_ff, nxt_hold;
    logic [FW-1:0] rdata_ff, nxt_rdata;
    logic d0o_ff, d0e_ff, d1o_ff, d1e_ff, nxt_d0o, nxt_d0e, nxt_d1o, nxt_d1e;
    logic step_ff, stand_ff, above_ff, drv_ff, dir_ff, auto_ff, idx_ff, idxt_ff;
    logic nxt_step, nxt_stand, nxt_above, nxt_drv, nxt_dir, nxt_auto, nxt_idx, nxt_idxt;
    gcs_seq_t seq_ff, nxt_seq;
    logic first_diag_pin_drive_style, second_diag_pin_drive_style;
    logic small_hyst, stop_en, direct_en, test_en;
    logic [15:0] hyst;
    logic [GCS_COIL_W-1:0] coil_a_raw, coil_b_raw;

    assign first_diag_pin_drive_style = cfg_ff[GCS_BIT_DIAG0_PP - 12];
    assign second_diag_pin_drive_style = cfg_ff[GCS_BIT_DIAG1_PP - 12];
    assign small_hyst = cfg_ff[GCS_BIT_SMALL_HYST - 12];
    assign stop_en = cfg_ff[GCS_BIT_STOP_EN - 12];
    assign direct_en = cfg_ff[GCS_BIT_DIRECT - 12];
    assign test_en = cfg_ff[GCS_BIT_TEST - 12];
    assign coil_a_raw = target_position_register_ff[GCS_COIL_A_LSB +: GCS_COIL_W];
    assign coil_b_raw = target_position_register_ff[GCS_COIL_B_LSB +: GCS_COIL_W];

    // Register writes and status flag updates
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_target = target_position_register_ff;
        nxt_hold = standstill_current_setting_ff;
        nxt_stat = global_status_flags_ff;
        nxt_cnt = uart_write_counter_ff;
        if (reg_wr && reg_addr == GCS_ADDR_GCONF) begin
            nxt_cfg = reg_wdata[GCS_BIT_TEST:GCS_BIT_DIAG0_PP];
        end
        if (reg_wr && reg_addr == GCS_ADDR_TARGET) begin
            nxt_target = reg_wdata[31:0];
        end
        if (reg_wr && reg_addr == GCS_ADDR_HOLD) begin
            nxt_hold = reg_wdata[4:0];
        end
        if (reg_wr && reg_addr == GCS_ADDR_STATUS) begin
            // Write 1 clears, write 0 keeps
            nxt_stat[GCS_BIT_RESET] = global_status_flags_ff[GCS_BIT_RESET]
                & ~reg_wdata[GCS_BIT_RESET];
            if (!overtemp) begin
                nxt_stat[GCS_BIT_DRV_ERR] = global_status_flags_ff[GCS_BIT_DRV_ERR]
                    & ~reg_wdata[GCS_BIT_DRV_ERR];
            end
            nxt_stat[GCS_BIT_PUMP_UV] = global_status_flags_ff[GCS_BIT_PUMP_UV]
                & ~reg_wdata[GCS_BIT_PUMP_UV];
        end
        // Set wins over a clear in the same cycle
        if (overtemp || short_det) begin
            nxt_stat[GCS_BIT_DRV_ERR] = 1'b1;
        end
        if (pump_undervoltage) begin
            nxt_stat[GCS_BIT_PUMP_UV] = 1'b1;
        end
        if (uart_sel && uart_wr_done) begin
            nxt_cnt = uart_write_counter_ff + 8'h01;
        end
    end

    // Read path, no side effects on reads
    always_comb begin
        nxt_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                GCS_ADDR_GCONF: nxt_rdata[GCS_BIT_TEST:GCS_BIT_DIAG0_PP] = cfg_ff;
                GCS_ADDR_STATUS: nxt_rdata[2:0] = global_status_flags_ff;
                GCS_ADDR_WRCNT: nxt_rdata[7:0] = uart_write_counter_ff;
                GCS_ADDR_TARGET: nxt_rdata[31:0] = target_position_register_ff;
                GCS_ADDR_HOLD: nxt_rdata[4:0] = standstill_current_setting_ff;
                default: nxt_rdata = '0;
            endcase
        end else begin
            nxt_rdata = rdata_ff;
        end
    end

    // Pins, sequencer halt and current control
    always_comb begin
        // Open collector pulls low when active; push-pull drives active high
        if (first_diag_pin_drive_style) begin
            nxt_d0o = diag0_event;
            nxt_d0e = 1'b1;
        end else begin
            nxt_d0o = 1'b0;
            nxt_d0e = diag0_event;
        end
        if (second_diag_pin_drive_style) begin
            nxt_d1o = diag1_event;
            nxt_d1e = 1'b1;
        end else begin
            nxt_d1o = 1'b0;
            nxt_d1e = diag1_event;
        end
        hyst = small_hyst ? (step_rate_ref >> GCS_HYST_SH_NARROW)
                          : (step_rate_ref >> GCS_HYST_SH_WIDE);
        if (above_ff) begin
            nxt_above = ({1'b0, step_rate} + {1'b0, hyst}) > {1'b0, step_rate_ref};
        end else begin
            nxt_above = {1'b0, step_rate} > ({1'b0, step_rate_ref} + {1'b0, hyst});
        end
        nxt_seq = seq_ff;
        case (seq_ff)
            GCS_RUN: begin
                if (stop_en && halt_input_pin) begin
                    nxt_seq = GCS_HALT;
                end
            end
            GCS_HALT: begin
                if (!(stop_en && halt_input_pin)) begin
                    nxt_seq = GCS_RUN;
                end
            end
            default: nxt_seq = GCS_RUN;
        endcase
        nxt_step = step_req && !(stop_en && halt_input_pin);
        nxt_stand = (nxt_seq == GCS_HALT);
        nxt_drv = !pump_undervoltage && !overtemp && !short_det;
        nxt_dir = direct_en;
        nxt_auto = !direct_en;
        // Test mode hands the index pin over to the analog test signal
        nxt_idx = test_en ? analog_test : index_normal;
        nxt_idxt = test_en ? analog_test : 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ff <= GCS_CFG_RESET;
            global_status_flags_ff <= GCS_STAT_RESET;
            uart_write_counter_ff <= GCS_CNT_RESET;
            target_position_register_ff <= GCS_TARGET_RESET;
            standstill_current_setting_ff <= GCS_HOLD_RESET;
            rdata_ff <= '0;
            d0o_ff <= 1'b0;
            d0e_ff <= 1'b0;
            d1o_ff <= 1'b0;
            d1e_ff <= 1'b0;
            above_ff <= 1'b0;
            seq_ff <= GCS_RUN;
            step_ff <= 1'b0;
            stand_ff <= 1'b0;
            drv_ff <= 1'b0;
            dir_ff <= 1'b0;
            auto_ff <= 1'b1;
            idx_ff <= 1'b0;
            idxt_ff <= 1'b0;
        end else begin
            cfg_ff <= nxt_cfg;
            global_status_flags_ff <= nxt_stat;
            uart_write_counter_ff <= nxt_cnt;
            target_position_register_ff <= nxt_target;
            standstill_current_setting_ff <= nxt_hold;
            rdata_ff <= nxt_rdata;
            d0o_ff <= nxt_d0o;
            d0e_ff <= nxt_d0e;
            d1o_ff <= nxt_d1o;
            d1e_ff <= nxt_d1e;
            above_ff <= nxt_above;
            seq_ff <= nxt_seq;
            step_ff <= nxt_step;
            stand_ff <= nxt_stand;
            drv_ff <= nxt_drv;
            dir_ff <= nxt_dir;
            auto_ff <= nxt_auto;
            idx_ff <= nxt_idx;
            idxt_ff <= nxt_idxt;
        end
    end

    gcs_coil_scale #(.CW(GCS_COIL_W)) u_scale_a (
        .clk(clk),
        .rst_b(rst_b),
        .coil_in(coil_a_raw),
        .scale(standstill_current_setting_ff),
        .coil_out(coil_a_current)
    );

    gcs_coil_scale #(.CW(GCS_COIL_W)) u_scale_b (
        .clk(clk),
        .rst_b(rst_b),
        .coil_in(coil_b_raw),
        .scale(standstill_current_setting_ff),
        .coil_out(coil_b_current)
    );

    assign reg_rdata = rdata_ff;
    assign first_diagnostic_pin_o = d0o_ff;
    assign first_diagnostic_pin_oe = d0e_ff;
    assign second_diagnostic_pin_o = d1o_ff;
    assign second_diagnostic_pin_oe = d1e_ff;
    assign step_out = step_ff;
    assign motor_standstill = stand_ff;
    assign rate_above = above_ff;
    assign driver_enable = drv_ff;
    assign direct_active = dir_ff;
    assign auto_regulation_en = auto_ff;
    assign encoder_index_pin = idx_ff;
    assign encoder_index_test = idxt_ff;

    property p_stop_halts;
        @(posedge clk) disable iff (!rst_b)
        (stop_en && halt_input_pin) |=> !step_out;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("step issued during stop");

    property p_cnt_inc;
        @(posedge clk) disable iff (!rst_b)
        (uart_sel && uart_wr_done)
            |=> (uart_write_counter_ff == $past(uart_write_counter_ff) + 8'h01);
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

    property p_cnt_spi;
        @(posedge clk) disable iff (!rst_b)
        !uart_sel |=> $stable(uart_write_counter_ff);
    endproperty
    a_cnt_spi: assert property (p_cnt_spi) else $error("counter moved under spi");

    property p_drv_err_set;
        @(posedge clk) disable iff (!rst_b)
        (overtemp || short_det) |=> global_status_flags_ff[GCS_BIT_DRV_ERR];
    endproperty
    a_drv_err_set: assert property (p_drv_err_set) else $error("driver error not set");

    property p_uv_drv_off;
        @(posedge clk) disable iff (!rst_b)
        pump_undervoltage |=> (!driver_enable && global_status_flags_ff[GCS_BIT_PUMP_UV]);
    endproperty
    a_uv_drv_off: assert property (p_uv_drv_off) else $error("driver on in undervoltage");

    property p_w0_keeps;
        @(posedge clk) disable iff (!rst_b)
        (reg_wr && reg_addr == GCS_ADDR_STATUS && !reg_wdata[GCS_BIT_RESET]
            && global_status_flags_ff[GCS_BIT_RESET]) |=> global_status_flags_ff[GCS_BIT_RESET];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) else $error("flag lost on zero write");

    property p_oc_style;
        @(posedge clk) disable iff (!rst_b)
        !first_diag_pin_drive_style ##1 !first_diag_pin_drive_style |-> !first_diagnostic_pin_o;
    endproperty
    a_oc_style: assert property (p_oc_style) else $error("open collector drove high");

    property p_auto_off;
        @(posedge clk) disable iff (!rst_b)
        direct_en ##1 direct_en |-> !auto_regulation_en;
    endproperty
    a_auto_off: assert property (p_auto_off) else $error("auto regulation in direct mode");
endmodule

// ---- test/gcs_host_model.sv ----
// Host-side model: register writes and reads, UART write completions
`timescale 1ns/1ps
module gcs_host_model (
    input wire logic clk,
    input wire logic [31:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic uart_wr_done
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 32'h0000_0000;
        uart_wr_done = 1'b0;
    end

    // One-cycle write strobe, fields held with it
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    // Read data is registered, so it is taken one cycle after the strobe
    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic uart_writes(input int n);
        repeat (n) begin
            @(negedge clk);
            uart_wr_done = 1'b1;
            @(negedge clk);
            uart_wr_done = 1'b0;
        end
    endtask
endmodule

// ---- test/global_config_status_regs_test.sv ----
// Self-checking bench for the global config and status registers
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: mismatch at line %0d", $time, `__LINE__); end end
module global_config_status_regs_test;
    import gcs_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, reg_wr, reg_rd, uart_sel = 1'b0, uart_wr_done;
    logic [6:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic overtemp = 1'b0, short_det = 1'b0, pump_undervoltage = 1'b0;
    logic diag0_event = 1'b0, diag1_event = 1'b0, halt_input_pin = 1'b0, step_req = 1'b0;
    logic [15:0] step_rate = 16'h0000, step_rate_ref = 16'h0400;
    logic analog_test = 1'b0, index_normal = 1'b1;
    logic d0o, d0e, d1o, d1e, step_out, motor_standstill, rate_above, driver_enable;
    logic direct_active, auto_regulation_en, encoder_index_pin, encoder_index_test;
    logic [8:0] coil_a_current, coil_b_current, ca, cb;
    logic [4:0] hold;
    integer seed = 63590;
    int miscompares = 0, checks_done = 0, n;

    always #5 clk = ~clk;

    gcs_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .uart_wr_done(uart_wr_done));

    gcs_regs dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .uart_sel(uart_sel),
        .uart_wr_done(uart_wr_done), .reg_rdata(reg_rdata), .overtemp(overtemp),
        .short_det(short_det), .pump_undervoltage(pump_undervoltage),
        .diag0_event(diag0_event), .diag1_event(diag1_event),
        .halt_input_pin(halt_input_pin), .step_req(step_req), .step_rate(step_rate),
        .step_rate_ref(step_rate_ref), .analog_test(analog_test), .index_normal(index_normal),
        .first_diagnostic_pin_o(d0o), .first_diagnostic_pin_oe(d0e),
        .second_diagnostic_pin_o(d1o), .second_diagnostic_pin_oe(d1e), .step_out(step_out),
        .motor_standstill(motor_standstill), .rate_above(rate_above),
        .driver_enable(driver_enable), .direct_active(direct_active),
        .auto_regulation_en(auto_regulation_en), .coil_a_current(coil_a_current),
        .coil_b_current(coil_b_current), .encoder_index_pin(encoder_index_pin),
        .encoder_index_test(encoder_index_test));

    // Positive coil values only, so truncating division matches the scaling
    function automatic logic [8:0] scaled(input logic [8:0] v, input logic [4:0] h);
        return 9'((int'(v) * (int'(h) + 1)) / 32);
    endfunction

    task automatic check_rd(input logic [6:0] a, input logic [31:0] e);
        host.rd(a, rv);
        `CHK(rv, e)
    endtask

    task automatic cfg(input logic [5:0] b);
        host.wr(GCS_ADDR_GCONF, {14'h0000, b, 12'h000});
        repeat (3) @(negedge clk);
    endtask

    task automatic print_verdict();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        check_rd(GCS_ADDR_STATUS, 32'h1);
        check_rd(GCS_ADDR_WRCNT, 32'h0);
        `CHK(auto_regulation_en, 1'b1)
        check_rd(7'h55, 32'h0);
        host.wr(GCS_ADDR_STATUS, 32'h0);
        check_rd(GCS_ADDR_STATUS, 32'h1);
        host.wr(GCS_ADDR_STATUS, 32'h1);
        check_rd(GCS_ADDR_STATUS, 32'h0);
        // Overtemperature: clear refused while it lasts
        overtemp = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(driver_enable, 1'b0)
        host.wr(GCS_ADDR_STATUS, 32'h2);
        check_rd(GCS_ADDR_STATUS, 32'h2);
        overtemp = 1'b0;
        host.wr(GCS_ADDR_STATUS, 32'h2);
        check_rd(GCS_ADDR_STATUS, 32'h0);
        short_det = 1'b1;
        @(negedge clk);
        short_det = 1'b0;
        check_rd(GCS_ADDR_STATUS, 32'h2);
        host.wr(GCS_ADDR_STATUS, 32'h2);
        pump_undervoltage = 1'b1;
        repeat (3) @(negedge clk);
        `CHK(driver_enable, 1'b0)
        pump_undervoltage = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(driver_enable, 1'b1)
        check_rd(GCS_ADDR_STATUS, 32'h4);
        host.wr(GCS_ADDR_STATUS, 32'h4);
        // Write counter: count, read twice, writes under SPI ignored, wrap
        n = ($random(seed) & 8'h3f) + 1;
        uart_sel = 1'b1;
        host.uart_writes(n);
        check_rd(GCS_ADDR_WRCNT, 32'(n));
        check_rd(GCS_ADDR_WRCNT, 32'(n));
        uart_sel = 1'b0;
        host.uart_writes(5);
        check_rd(GCS_ADDR_WRCNT, 32'(n));
        uart_sel = 1'b1;
        host.uart_writes(256 - n);
        check_rd(GCS_ADDR_WRCNT, 32'h0);
        host.uart_writes(1);
        check_rd(GCS_ADDR_WRCNT, 32'h1);
        uart_sel = 1'b0;
        // Diagnostic pin drive styles against both event levels
        for (int s = 0; s < 4; s++) begin
            cfg(6'(s));
            for (int e = 0; e < 2; e++) begin
                diag0_event = 1'(e);
                diag1_event = 1'(e);
                repeat (3) @(negedge clk);
                `CHK(d0o, s[0] ? 1'(e) : 1'b0)
                `CHK(d0e, s[0] ? 1'b1 : 1'(e))
                `CHK(d1o, s[1] ? 1'(e) : 1'b0)
                `CHK(d1e, s[1] ? 1'b1 : 1'(e))
            end
        end
        diag0_event = 1'b0;
        diag1_event = 1'b0;
        // Fall from above to ref - 48: inside 1/16 band, outside 1/32 band
        for (int h = 0; h < 2; h++) begin
            cfg({3'b000, 1'(h), 2'b00});
            step_rate = 16'd1200;
            repeat (4) @(negedge clk);
            `CHK(rate_above, 1'b1)
            step_rate = 16'd976;
            repeat (4) @(negedge clk);
            `CHK(rate_above, h == 0 ? 1'b1 : 1'b0)
            step_rate = 16'h0000;
        end
        // Stop input gates steps only while enabled
        for (int k = 0; k < 3; k++) begin
            cfg(k == 2 ? 6'h00 : 6'h08);
            halt_input_pin = (k != 1);
            step_req = 1'b1;
            @(negedge clk);
            step_req = 1'b0;
            `CHK(step_out, k != 0)
            `CHK(motor_standstill, k == 0)
        end
        halt_input_pin = 1'b0;
        // Direct coil currents scaled by the standstill setting
        hold = 5'($random(seed));
        ca = {1'b0, 8'($random(seed))};
        cb = {1'b0, 8'($random(seed))};
        host.wr(GCS_ADDR_HOLD, {27'h0, hold});
        host.wr(GCS_ADDR_TARGET, {7'h00, cb, 7'h00, ca});
        cfg(6'h10);
        repeat (2) @(negedge clk);
        `CHK(coil_a_current, scaled(ca, hold))
        `CHK(coil_b_current, scaled(cb, hold))
        `CHK(direct_active, 1'b1)
        `CHK(auto_regulation_en, 1'b0)
        // Full-scale hold passes any coil value through, negative ones too
        host.wr(GCS_ADDR_HOLD, 32'h0000_001f);
        host.wr(GCS_ADDR_TARGET, 32'h0180_00ff);
        repeat (3) @(negedge clk);
        `CHK(coil_a_current, 9'h0ff)
        `CHK(coil_b_current, 9'h180)
        // Test output takes over the index pin, both levels of the test signal
        analog_test = 1'($random(seed));
        index_normal = 1'b1;
        cfg(6'h20);
        `CHK(encoder_index_pin, analog_test)
        `CHK(encoder_index_test, analog_test)
        analog_test = ~analog_test;
        repeat (2) @(negedge clk);
        `CHK(encoder_index_pin, analog_test)
        cfg(6'h10);
        `CHK(encoder_index_pin, 1'b1)
        check_rd(GCS_ADDR_GCONF, 32'h0001_0000);
        // Reset in mid-run brings back the reset flag and clears the rest
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check_rd(GCS_ADDR_STATUS, 32'h1);
        check_rd(GCS_ADDR_WRCNT, 32'h0);
        check_rd(GCS_ADDR_GCONF, 32'h0);
        `CHK(direct_active, 1'b0)
        `CHK(coil_a_current, 9'h000)
        print_verdict();
    end
endmodule
